// ==== shared/thermal_pkg.sv ====
// Package: register map, field positions, reset values and encodings of the thermal limit block
package thermal_pkg;
  // =========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_HYST      = 8'h04;
  localparam logic [7:0] OFF_LIM_LOC   = 8'h08;
  localparam logic [7:0] OFF_LIM_R1A   = 8'h0C;
  localparam logic [7:0] OFF_LIM_R1B   = 8'h10;
  localparam logic [7:0] OFF_LIM_R2A   = 8'h14;
  localparam logic [7:0] OFF_LIM_R2B   = 8'h18;
  localparam logic [7:0] OFF_LIM_R3    = 8'h1C;
  localparam logic [7:0] OFF_LIM_R4    = 8'h20;
  localparam logic [7:0] OFF_MASK1     = 8'h24;
  localparam logic [7:0] OFF_MASK2     = 8'h28;
  localparam logic [7:0] OFF_MASK3     = 8'h2C;
  localparam logic [7:0] OFF_STAT_OUT  = 8'h30;
  localparam logic [7:0] OFF_STAT_DIO  = 8'h34;
  localparam logic [7:0] OFF_TEMP_SEL  = 8'h38;
  localparam logic [7:0] OFF_TEMP_S    = 8'h3C;
  localparam logic [7:0] OFF_TEMP_U    = 8'h40;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h44;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h48;
  // =========================================
  // Control field positions
  localparam int CTRL_EN_LSB  = 0;  // Channel enables, 5 bits
  localparam int CTRL_FQ3     = 5;  // Fault queue remote 3
  localparam int CTRL_FQ4     = 6;  // Fault queue remote 4
  localparam int CTRL_FLT1    = 7;  // Filter remote 1
  localparam int CTRL_FLT2    = 8;  // Filter remote 2
  // Diode status bits
  localparam int DIO_R2_BIT   = 0;
  localparam int DIO_R1_BIT   = 1;
  // =========================================
  // Reset values (limits in whole degrees, 8-bit)
  localparam logic [8:0] CTRL_RST     = 9'h17F;
  localparam logic [7:0] LIM_85_RST   = 8'h55;
  localparam logic [7:0] LIM_110_RST  = 8'h6E;
  localparam logic [7:0] HYST_RST     = 8'h0A;
  localparam logic [4:0] MASK1_RST    = 5'h19;  // Local, R3, R4 masked
  localparam logic [4:0] MASK2_RST    = 5'h00;
  localparam logic [4:0] MASK3_RST    = 5'h07;  // Local, R1, R2 masked
  // =========================================
  // Encodings
  localparam int NCH                  = 5;
  localparam logic [2:0] FQ_DEPTH     = 3'h3;
  localparam logic [15:0] FAULT_SIGNED = 16'h8000;  // -128.000 degrees
  localparam logic [15:0] FAULT_UNSIGNED = 16'h0000;
  localparam logic [15:0] MASK_11BIT  = 16'hFFE0;
  localparam logic [15:0] MASK_13BIT  = 16'hFFF8;
endpackage : thermal_pkg

// ==== src/limit_judge.sv ====
// Hysteresis comparator with optional three-deep fault queue for one limit
`timescale 1ns/10ps
module limit_judge (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Conversion sample
  input  wire logic        sample_stb,
  input  wire logic        enable,
  input  wire logic        queue_on,
  input  wire logic signed [15:0] temp,
  input  wire logic [7:0]  limit,
  input  wire logic [7:0]  hyst,
  // Result
  output logic             over
);
  logic signed [15:0] lim_w;
  logic signed [15:0] low_w;
  logic               hi_w;
  logic               lo_w;
  logic [2:0]         cnt_r;
  // Limit and release point in the left-justified temperature format
  assign lim_w = signed'({limit, 8'h00});
  assign low_w = signed'({limit, 8'h00}) - signed'({hyst, 8'h00});
  assign hi_w  = temp > lim_w;
  assign lo_w  = temp < low_w;
  // Set above limit, clear below limit minus hysteresis, queued when asked
  always_ff @(posedge clk_sys) begin
    if (reset || !enable) begin
      over  <= 1'b0;
      cnt_r <= 3'h0;
    end else if (sample_stb) begin
      if ((!over && hi_w) || (over && lo_w)) begin
        if (!queue_on || cnt_r == thermal_pkg::FQ_DEPTH - 3'h1) begin
          over  <= !over;
          cnt_r <= 3'h0;
        end else begin
          cnt_r <= cnt_r + 3'h1;
        end
      end else begin
        cnt_r <= 3'h0;
      end
    end
  end
endmodule : limit_judge

// ==== src/thermal_limit_compare.sv ====
// Thermal limit compare: result encoding, limits, status, masks and critical outputs
`timescale 1ns/10ps
module thermal_limit_compare (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Conversion results from the converter, same clock
  input  wire logic        conv_done,
  input  wire logic [2:0]  conv_chan,
  input  wire logic [15:0] conv_raw,
  input  wire logic [15:0] conv_filt,
  input  wire logic        conv_diode_fault,
  // Critical open-drain outputs
  output logic             crit_out_first_o,
  output logic             crit_out_first_oe,
  output logic             crit_out_second_o,
  output logic             crit_out_second_oe,
  output logic             crit_out_third_o,
  output logic             crit_out_third_oe,
  // Interrupt
  output logic             irq
);
  // =========================================
  // Registers
  logic [8:0]  ctrl_r;
  logic [7:0]  hyst_r;
  logic [7:0]  lim_r [0:6];       // loc, r1a, r1b, r2a, r2b, r3, r4
  logic [4:0]  mask_r [0:2];
  logic [15:0] temp_s_r [0:4];
  logic [15:0] temp_u_r [0:4];
  logic [1:0]  dio_r;
  logic [2:0]  tsel_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [4:0]  stb_r;
  logic [15:0] samp_r;
  logic        fault_r;
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [2:0]  crit_prev_r;

  // =========================================
  // Bus decode
  wire         addr_ph = hsel && hready && htrans[1];
  wire         do_wr   = wr_pend_r;
  wire [7:0]   raddr   = haddr[7:0];
  wire [31:0]  wd      = hwdata;

  // Store a write address for the data phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      wr_addr_r <= haddr[7:0];
    end
  end

  // =========================================
  // Sample capture and encoding
  wire        filt1   = ctrl_r[thermal_pkg::CTRL_FLT1];
  wire        filt2   = ctrl_r[thermal_pkg::CTRL_FLT2];
  wire        use_flt = (conv_chan == 3'h1 && filt1) || (conv_chan == 3'h2 && filt2);
  wire        is_rem  = conv_chan != 3'h0;
  wire        chan_ok = conv_chan < 3'h5;
  wire [15:0] src_w   = use_flt ? conv_filt : conv_raw;
  wire [15:0] fmt_m   = use_flt ? thermal_pkg::MASK_13BIT
                                : thermal_pkg::MASK_11BIT;
  wire [15:0] sgn_w   = (is_rem && conv_diode_fault) ? thermal_pkg::FAULT_SIGNED
                                                     : (src_w & fmt_m);
  // Unsigned view: clamp negatives to zero, fault reads zero
  wire [15:0] uns_w   = (is_rem && conv_diode_fault) ? thermal_pkg::FAULT_UNSIGNED
                      : (sgn_w[15] ? 16'h0000 : (src_w & fmt_m));

  // Stored readings; unsigned keeps the unclamped converter word for remote channels without a diode fault
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < thermal_pkg::NCH; i++) begin
        temp_s_r[i] <= 16'h0000;
        temp_u_r[i] <= 16'h0000;
      end
      stb_r   <= 5'h00;
      samp_r  <= 16'h0000;
      fault_r <= 1'b0;
    end else begin
      stb_r <= 5'h00;
      if (conv_done && chan_ok) begin
        temp_s_r[conv_chan] <= sgn_w;
        temp_u_r[conv_chan] <= (is_rem && conv_diode_fault) ? uns_w
                               : (is_rem ? (src_w & fmt_m) : uns_w);
        stb_r[conv_chan]    <= 1'b1;
        samp_r              <= sgn_w;
        fault_r             <= is_rem && conv_diode_fault;
      end
    end
  end

  // =========================================
  // Comparators: bit order loc, r1, r2, r3, r4
  logic [4:0] over_a;  // first-level results
  logic [4:0] over_b;  // second-level results
  wire  [4:0] en_w = ctrl_r[4:0];

  // Local and remotes 3, 4 share one result for both levels
  limit_judge u_loc (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[0]),
    .enable(en_w[0]), .queue_on(1'b0), .temp(samp_r), .limit(lim_r[0]),
    .hyst(hyst_r), .over(over_a[0]));
  limit_judge u_r1a (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[1]),
    .enable(en_w[1]), .queue_on(1'b0), .temp(samp_r), .limit(lim_r[1]),
    .hyst(hyst_r), .over(over_a[1]));
  limit_judge u_r1b (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[1]),
    .enable(en_w[1]), .queue_on(1'b0), .temp(samp_r), .limit(lim_r[2]),
    .hyst(hyst_r), .over(over_b[1]));
  limit_judge u_r2a (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[2]),
    .enable(en_w[2]), .queue_on(1'b0), .temp(samp_r), .limit(lim_r[3]),
    .hyst(hyst_r), .over(over_a[2]));
  limit_judge u_r2b (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[2]),
    .enable(en_w[2]), .queue_on(1'b0), .temp(samp_r), .limit(lim_r[4]),
    .hyst(hyst_r), .over(over_b[2]));
  limit_judge u_r3 (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[3]),
    .enable(en_w[3]), .queue_on(ctrl_r[thermal_pkg::CTRL_FQ3]), .temp(samp_r),
    .limit(lim_r[5]), .hyst(hyst_r), .over(over_a[3]));
  limit_judge u_r4 (.clk_sys(clk_sys), .reset(reset), .sample_stb(stb_r[4]),
    .enable(en_w[4]), .queue_on(ctrl_r[thermal_pkg::CTRL_FQ4]), .temp(samp_r),
    .limit(lim_r[6]), .hyst(hyst_r), .over(over_a[4]));

  // Single-limit channels reuse their one result at the second level
  assign over_b[0] = over_a[0];
  assign over_b[3] = over_a[3];
  assign over_b[4] = over_a[4];

  // =========================================
  // Per-output status and masking
  wire [4:0] stat1 = over_a;
  wire [4:0] stat2 = over_b;
  wire [4:0] stat3 = over_b;
  wire [2:0] crit_w = {|(stat3 & ~mask_r[2]), |(stat2 & ~mask_r[1]),
                       |(stat1 & ~mask_r[0])};
  wire [2:0] crit_rise = crit_w & ~crit_prev_r;

  // Open-drain drive: enable pulls low while active
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      crit_out_first_oe  <= 1'b0;
      crit_out_second_oe <= 1'b0;
      crit_out_third_oe  <= 1'b0;
      crit_out_first_o   <= 1'b0;
      crit_out_second_o  <= 1'b0;
      crit_out_third_o   <= 1'b0;
      crit_prev_r        <= 3'h0;
    end else begin
      crit_out_first_oe  <= crit_w[0];
      crit_out_second_oe <= crit_w[1];
      crit_out_third_oe  <= crit_w[2];
      crit_prev_r        <= crit_w;
    end
  end

  // =========================================
  // Diode-missing status, cleared by writing one; set wins
  wire [1:0] dio_set = {fault_r && stb_r[1], fault_r && stb_r[2]};
  wire [1:0] dio_clr = (do_wr && wr_addr_r == thermal_pkg::OFF_STAT_DIO) ? wd[1:0] : 2'h0;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      dio_r <= 2'h0;
    end else begin
      dio_r <= dio_set | (dio_r & ~dio_clr);
    end
  end

  // Interrupt status: a rising critical output sets its bit
  wire [2:0] irq_clr = (do_wr && wr_addr_r == thermal_pkg::OFF_IRQ_STAT) ? wd[2:0] : 3'h0;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_stat_r <= 3'h0;
      irq       <= 1'b0;
    end else begin
      irq_stat_r <= crit_rise | (irq_stat_r & ~irq_clr);
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end

  // =========================================
  // Writable registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_r     <= thermal_pkg::CTRL_RST;
      hyst_r     <= thermal_pkg::HYST_RST;
      lim_r[0]   <= thermal_pkg::LIM_85_RST;
      lim_r[1]   <= thermal_pkg::LIM_110_RST;
      lim_r[2]   <= thermal_pkg::LIM_85_RST;
      lim_r[3]   <= thermal_pkg::LIM_110_RST;
      lim_r[4]   <= thermal_pkg::LIM_85_RST;
      lim_r[5]   <= thermal_pkg::LIM_85_RST;
      lim_r[6]   <= thermal_pkg::LIM_85_RST;
      mask_r[0]  <= thermal_pkg::MASK1_RST;
      mask_r[1]  <= thermal_pkg::MASK2_RST;
      mask_r[2]  <= thermal_pkg::MASK3_RST;
      tsel_r     <= 3'h0;
      irq_mask_r <= 3'h0;
    end else if (do_wr) begin
      unique case (wr_addr_r)
        thermal_pkg::OFF_CTRL:     ctrl_r     <= wd[8:0];
        thermal_pkg::OFF_HYST:     hyst_r     <= wd[7:0];
        thermal_pkg::OFF_LIM_LOC:  lim_r[0]   <= wd[7:0];
        thermal_pkg::OFF_LIM_R1A:  lim_r[1]   <= wd[7:0];
        thermal_pkg::OFF_LIM_R1B:  lim_r[2]   <= wd[7:0];
        thermal_pkg::OFF_LIM_R2A:  lim_r[3]   <= wd[7:0];
        thermal_pkg::OFF_LIM_R2B:  lim_r[4]   <= wd[7:0];
        thermal_pkg::OFF_LIM_R3:   lim_r[5]   <= wd[7:0];
        thermal_pkg::OFF_LIM_R4:   lim_r[6]   <= wd[7:0];
        thermal_pkg::OFF_MASK1:    mask_r[0]  <= wd[4:0];
        thermal_pkg::OFF_MASK2:    mask_r[1]  <= wd[4:0];
        thermal_pkg::OFF_MASK3:    mask_r[2]  <= wd[4:0];
        thermal_pkg::OFF_TEMP_SEL: tsel_r     <= (wd[2:0] < 3'h5) ? wd[2:0] : 3'h0;
        thermal_pkg::OFF_IRQ_MASK: irq_mask_r <= wd[2:0];
        default: ;
      endcase
    end
  end

  // =========================================
  // Read mux, registered in the address phase
  logic [31:0] rd_w;
  always_comb begin
    rd_w = 32'h0000_0000;
    unique case (raddr)
      thermal_pkg::OFF_CTRL:     rd_w = {23'h0, ctrl_r};
      thermal_pkg::OFF_HYST:     rd_w = {24'h0, hyst_r};
      thermal_pkg::OFF_LIM_LOC:  rd_w = {24'h0, lim_r[0]};
      thermal_pkg::OFF_LIM_R1A:  rd_w = {24'h0, lim_r[1]};
      thermal_pkg::OFF_LIM_R1B:  rd_w = {24'h0, lim_r[2]};
      thermal_pkg::OFF_LIM_R2A:  rd_w = {24'h0, lim_r[3]};
      thermal_pkg::OFF_LIM_R2B:  rd_w = {24'h0, lim_r[4]};
      thermal_pkg::OFF_LIM_R3:   rd_w = {24'h0, lim_r[5]};
      thermal_pkg::OFF_LIM_R4:   rd_w = {24'h0, lim_r[6]};
      thermal_pkg::OFF_MASK1:    rd_w = {27'h0, mask_r[0]};
      thermal_pkg::OFF_MASK2:    rd_w = {27'h0, mask_r[1]};
      thermal_pkg::OFF_MASK3:    rd_w = {27'h0, mask_r[2]};
      thermal_pkg::OFF_STAT_OUT: rd_w = {5'h0, crit_w, 3'h0, stat3, 3'h0, stat2,
                                         3'h0, stat1};
      thermal_pkg::OFF_STAT_DIO: rd_w = {30'h0, dio_r};
      thermal_pkg::OFF_TEMP_SEL: rd_w = {29'h0, tsel_r};
      thermal_pkg::OFF_TEMP_S:   rd_w = {16'h0, temp_s_r[tsel_r]};
      thermal_pkg::OFF_TEMP_U:   rd_w = {16'h0, temp_u_r[tsel_r]};
      thermal_pkg::OFF_IRQ_STAT: rd_w = {29'h0, irq_stat_r};
      thermal_pkg::OFF_IRQ_MASK: rd_w = {29'h0, irq_mask_r};
      default:                   rd_w = 32'h0000_0000;
    endcase
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ph && !hwrite) begin
        hrdata <= rd_w;
      end
    end
  end
endmodule : thermal_limit_compare

// ==== sim/thermal_limit_compare_assertions.sv ====
// Checker: bus answer, open-drain and event timing properties of the thermal limit block
`timescale 1ns/10ps
module thermal_limit_compare_checker (
  // Clock, reset and bus
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Events and outputs
  input wire logic        conv_done,
  input wire logic        crit_out_first_o,
  input wire logic        crit_out_first_oe,
  input wire logic        crit_out_second_o,
  input wire logic        crit_out_second_oe,
  input wire logic        crit_out_third_o,
  input wire logic        crit_out_third_oe,
  input wire logic        irq
);
  // =========================================
  // Helpers
  logic [2:0] oe;
  logic       rd_ap, wr_ap, wr_near;
  logic [3:0] wr_age_r;
  assign oe      = {crit_out_third_oe, crit_out_second_oe, crit_out_first_oe};
  assign rd_ap   = hsel & hready & htrans[1] & ~hwrite;
  assign wr_ap   = hsel & hready & htrans[1] & hwrite;
  assign wr_near = (wr_age_r < 4'h7);
  // Cycles since the last register write, saturating; a write may move outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_age_r <= 4'hF;
    end else if (wr_ap) begin
      wr_age_r <= 4'h0;
    end else if (wr_age_r != 4'hF) begin
      wr_age_r <= wr_age_r + 4'h1;
    end
  end
  // =========================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
  property p_od_low; !(crit_out_first_o | crit_out_second_o | crit_out_third_o); endproperty
  a_od_low: assert property (p_od_low) else $error("critical line driven high");
  property p_rise; ((oe & ~$past(oe)) != 3'h0) |-> $past(conv_done, 3) || wr_near; endproperty
  a_rise: assert property (p_rise) else $error("output asserted without cause");
  property p_fall; ((~oe & $past(oe)) != 3'h0) |-> $past(conv_done, 3) || wr_near; endproperty
  a_fall: assert property (p_fall) else $error("output released without cause");
  property p_step;
    conv_done && !$past(conv_done) && !$past(conv_done, 2) && !wr_near |=> $stable(oe) [*2];
  endproperty
  a_step: assert property (p_step) else $error("output moved before its latency");
  property p_irq_up;
    $rose(irq) |-> $past(conv_done, 4) || $past(conv_done, 5) || wr_near;
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("interrupt raised without cause");
  property p_irq_down; $fell(irq) |-> wr_near; endproperty
  a_irq_down: assert property (p_irq_down) else $error("interrupt dropped without write");
  property p_hold; !$past(rd_ap) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed without read");
  property p_unmapped;
    rd_ap && haddr[31:8] == 24'h0 && haddr[7:0] > 8'h48 |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Main scenarios reached
  c_rise: cover property ((oe & ~$past(oe)) != 3'h0);
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (rd_ap && haddr[7:0] > 8'h48);
endmodule : thermal_limit_compare_checker

bind thermal_limit_compare thermal_limit_compare_checker i_chk (
  .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .conv_done(conv_done), .crit_out_first_o(crit_out_first_o),
  .crit_out_first_oe(crit_out_first_oe), .crit_out_second_o(crit_out_second_o),
  .crit_out_second_oe(crit_out_second_oe), .crit_out_third_o(crit_out_third_o),
  .crit_out_third_oe(crit_out_third_oe), .irq(irq));

// ==== sim/thermal_conv_model.sv ====
// Converter and critical-line receiver model facing the thermal limit block
`timescale 1ns/10ps
module thermal_conv_model (
  // Clock
  input  wire logic        clk_sys,
  // Conversion results
  output logic             conv_done,
  output logic [2:0]       conv_chan,
  output logic [15:0]      conv_raw,
  output logic [15:0]      conv_filt,
  output logic             conv_diode_fault,
  // Critical lines
  input  wire logic [2:0]  crit_o,
  input  wire logic [2:0]  crit_oe,
  output logic [2:0]       crit_out_n
);
  int          req_n = 0;
  int          ack_n = 0;
  logic [2:0]  p_chan;
  logic [15:0] p_raw, p_filt;
  logic        p_fault;
  // Line level with external pull-up: low only while driven low
  assign crit_out_n = ~(crit_oe & ~crit_o);
  // Offer one conversion result at the next clock edge
  task automatic send(input logic [2:0] c, input logic [15:0] r, input logic [15:0] f,
                      input logic x);
    p_chan  = c;
    p_raw   = r;
    p_filt  = f;
    p_fault = x;
    req_n++;
    @(posedge clk_sys);
  endtask : send
  // One-cycle strobe; data lines toggle when no result stands so stale values never match
  initial begin
    conv_done        = 1'b0;
    conv_chan        = 3'h7;
    conv_raw         = 16'h0;
    conv_filt        = 16'h0;
    conv_diode_fault = 1'b0;
  end
  always @(posedge clk_sys) begin
    conv_done        <= (req_n != ack_n);
    conv_chan        <= (req_n != ack_n) ? p_chan : ~conv_chan;
    conv_raw         <= (req_n != ack_n) ? p_raw : ~conv_raw;
    conv_filt        <= (req_n != ack_n) ? p_filt : ~conv_filt;
    conv_diode_fault <= (req_n != ack_n) ? p_fault : ~conv_diode_fault;
    ack_n            <= req_n;
  end
endmodule : thermal_conv_model

// ==== sim/thermal_limit_compare_tb.sv ====
// Testbench: register defaults, limits, masks, hysteresis, fault queue and diode faults
`timescale 1ns/10ps
module thermal_limit_compare_tb;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d;} row_s;
  // =========================================
  // Signals
  logic        clk_sys, reset, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic        conv_done, conv_diode_fault;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, conv_chan, crit_out_n;
  logic [15:0] conv_raw, conv_filt;
  wire  [2:0]  crit_o, crit_oe;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  // Ordinary cases: register defaults, unmapped place, upper bits
  row_s rows [20] = '{
    '{1'b0, 8'h00, 32'h17F}, '{1'b0, 8'h04, 32'h0A}, '{1'b0, 8'h08, 32'h55},
    '{1'b0, 8'h0C, 32'h6E}, '{1'b0, 8'h10, 32'h55}, '{1'b0, 8'h14, 32'h6E},
    '{1'b0, 8'h18, 32'h55}, '{1'b0, 8'h1C, 32'h55}, '{1'b0, 8'h20, 32'h55},
    '{1'b0, 8'h24, 32'h19}, '{1'b0, 8'h28, 32'h00}, '{1'b0, 8'h2C, 32'h07},
    '{1'b0, 8'h30, 32'h00}, '{1'b0, 8'h34, 32'h00}, '{1'b0, 8'h48, 32'h00},
    '{1'b0, 8'h80, 32'h00}, '{1'b1, 8'h80, 32'hFFFFFFFF}, '{1'b0, 8'h80, 32'h00},
    '{1'b1, 8'h04, 32'hFFFFFF0C}, '{1'b0, 8'h04, 32'h0C}};
  assign hready = hreadyout;
  thermal_limit_compare i_dut (
    .clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done), .conv_chan(conv_chan),
    .conv_raw(conv_raw), .conv_filt(conv_filt), .conv_diode_fault(conv_diode_fault),
    .crit_out_first_o(crit_o[0]), .crit_out_first_oe(crit_oe[0]),
    .crit_out_second_o(crit_o[1]), .crit_out_second_oe(crit_oe[1]),
    .crit_out_third_o(crit_o[2]), .crit_out_third_oe(crit_oe[2]), .irq(irq));
  thermal_conv_model i_conv (
    .clk_sys(clk_sys), .conv_done(conv_done), .conv_chan(conv_chan), .conv_raw(conv_raw),
    .conv_filt(conv_filt), .conv_diode_fault(conv_diode_fault), .crit_o(crit_o),
    .crit_oe(crit_oe), .crit_out_n(crit_out_n));
  // =========================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One single word transfer; entered just after a clock edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdchk
  // One conversion, then wait past the interrupt latency
  task automatic cv(input logic [2:0] c, input logic [15:0] r, input logic [15:0] f,
                    input logic x);
    i_conv.send(c, r, f, x);
    repeat (6) @(posedge clk_sys);
  endtask : cv
  task automatic oechk(input logic [2:0] e);
    chk({29'h0, crit_oe}, {29'h0, e});
  endtask : oechk
  task automatic end_sim;
    $display("Errors: %0d, compares: %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // =========================================
  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_sim();
    end
  end
  // =========================================
  // Main sequence
  initial begin
    reset  = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk({28'h0, hreadyout, crit_oe}, 32'h8);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rd, rows[i].d);
    end
    // Local over limit: only the unmasked second output, then the interrupt path
    cv(3'h0, 16'h561F, 16'h0, 1'b0);
    oechk(3'b010);
    chk({29'h0, crit_out_n}, 32'h5);
    rdchk(8'h30, 32'h02010101);
    bus(1'b1, 8'h38, 32'h0);
    rdchk(8'h3C, 32'h5600);
    rdchk(8'h44, 32'h2);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 8'h48, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 8'h44, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    // Hysteresis band holds, a negative reading releases
    cv(3'h0, 16'h5000, 16'h0, 1'b0);
    oechk(3'b010);
    cv(3'h0, 16'hE71F, 16'h0, 1'b0);
    oechk(3'b000);
    rdchk(8'h3C, 32'hE700);
    // Remote one: two levels, raw reading while its filter is off
    cv(3'h1, 16'h6F00, 16'h0, 1'b0);
    oechk(3'b011);
    cv(3'h1, 16'h6000, 16'h0, 1'b0);
    oechk(3'b010);
    cv(3'h1, 16'h0, 16'h0, 1'b0);
    oechk(3'b000);
    // Remote two filtered: filtered word decides and is read back
    cv(3'h2, 16'h0, 16'h6F0F, 1'b0);
    oechk(3'b011);
    bus(1'b1, 8'h38, 32'h2);
    rdchk(8'h40, 32'h6F08);
    cv(3'h2, 16'h0, 16'h0, 1'b0);
    oechk(3'b000);
    // Remote three queued: third conversion asserts, disabling releases
    repeat (2) begin
      cv(3'h3, 16'h5600, 16'h0, 1'b0);
      oechk(3'b000);
    end
    cv(3'h3, 16'h5600, 16'h0, 1'b0);
    oechk(3'b110);
    bus(1'b1, 8'h00, 32'h177);
    repeat (4) @(posedge clk_sys);
    oechk(3'b000);
    // Remote four with its queue off acts at once; channel five is ignored
    bus(1'b1, 8'h00, 32'h13F);
    cv(3'h4, 16'h5600, 16'h0, 1'b0);
    oechk(3'b110);
    cv(3'h4, 16'h0, 16'h0, 1'b0);
    cv(3'h5, 16'h7F00, 16'h7F00, 1'b0);
    oechk(3'b000);
    // Diode faults on remotes one and two
    cv(3'h1, 16'h7F00, 16'h7F00, 1'b1);
    oechk(3'b000);
    bus(1'b1, 8'h38, 32'h1);
    rdchk(8'h3C, 32'h8000);
    rdchk(8'h40, 32'h0);
    rdchk(8'h34, 32'h2);
    bus(1'b1, 8'h34, 32'h2);
    rdchk(8'h34, 32'h0);
    cv(3'h2, 16'h1234, 16'h1234, 1'b1);
    rdchk(8'h34, 32'h1);
    // Mid-run reset: outputs, interrupt and sticky status return to idle
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    chk({27'h0, irq, hreadyout, crit_oe}, 32'h8);
    rdchk(8'h34, 32'h0);
    end_sim();
  end
endmodule : thermal_limit_compare_tb
